// *** inc/borl_pkg.sv ***
/*
  borl_pkg: shared constants, register map and state struct for the
  binary output relay drive logic.
  assumes: one aclk domain, axi4-lite register access, 32-bit data.
*/
package borl_pkg;
  localparam int unsigned NUM_SLOTS = 7;      // assignable input slots
  localparam int unsigned SIG_W     = 32;     // width of internal signal list
  localparam int unsigned SEL_W     = 5;      // selector width into the list
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00; // latch, relay invert
  localparam logic [7:0] OFS_ACKSEL  = 8'h04; // acknowledgement source
  localparam logic [7:0] OFS_SLOTINV = 8'h08; // per-slot inversion bits
  localparam logic [7:0] OFS_STATUS  = 8'h0c; // relay state, read only
  localparam logic [7:0] OFS_SEL0    = 8'h10; // slot 0 selector, +4 per slot
  // field positions
  localparam int unsigned BIT_LATCH   = 0;    // latch enable
  localparam int unsigned BIT_RLYINV  = 1;    // whole relay inversion
  localparam int unsigned BIT_SLOTEN  = 8;    // selector enable bit
  localparam int unsigned BIT_ST_RLY  = 0;    // driven relay level
  localparam int unsigned BIT_ST_HOLD = 1;    // latch holding
  localparam int unsigned BIT_ST_REQ  = 2;    // raw pick-up request
  // reset values
  localparam logic       RST_LATCH  = 1'b0;
  localparam logic       RST_RLYINV = 1'b0;
  localparam logic [NUM_SLOTS-1:0] RST_SLOTINV = 7'h00;
  localparam logic [SEL_W-1:0]     RST_SEL     = 5'h00;
  localparam logic       RST_SLOTEN = 1'b0;
  localparam logic [SEL_W-1:0]     RST_ACKSEL  = 5'h1f;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic                        awdone;  // write address captured
    logic [7:0]                  awaddr;  // captured write address
    logic                        wdone;   // write data captured
    logic [31:0]                 wdata;   // captured write data
    logic [3:0]                  wstrb;   // captured strobes
    logic                        bvalid;  // write response pending
    logic [1:0]                  bresp;   // write response code
    logic                        rvalid;  // read data pending
    logic [31:0]                 rdata;   // read data
    logic [1:0]                  rresp;   // read response code
    logic                        latch_en;  // latch setting
    logic                        rly_inv;   // relay inversion setting
    logic [NUM_SLOTS-1:0]        slot_inv;  // per-slot inversion
    logic [NUM_SLOTS-1:0]        slot_en;   // slot assigned
    logic [NUM_SLOTS*SEL_W-1:0]  slot_sel;  // slot selectors
    logic [SEL_W-1:0]            ack_sel;   // acknowledgement selector
    logic                        hold;      // latch holding picked-up state
    logic                        relay;     // registered relay drive
  } borl_state_t;
endpackage : borl_pkg

// *** core/borl_relay.sv ***
/*
  borl_relay: drive logic for one binary output relay with per-slot
  selection and inversion, optional latch and acknowledgement release.
  assumes: sig_list is synchronous to aclk; an axi4-lite master writes
  the settings; ack sources of other relays are handled elsewhere.
*/
// Summary of operation
// [RQ1] latch holds relay picked up once set
// [RQ2] acknowledge releases latch only when latching enabled
// [RQ3] each relay has own acknowledgement selector
// [RQ4] relay inversion complements the driven relay state
// [RQ5] each slot has own inversion, default off
// [RQ6] slots are ORed into pick-up request
`timescale 1ns/10ps
module borl_relay (
  input  wire logic                       aclk,     // 100 MHz clock
  input  wire logic                       aresetn,  // sync reset, low active
  input  wire logic [borl_pkg::SIG_W-1:0] sig_list, // internal signal list
  input  wire logic                       awvalid,  // write address valid
  output logic                            awready,  // write address ready
  input  wire logic [7:0]                 awaddr,   // write byte address
  input  wire logic                       wvalid,   // write data valid
  output logic                            wready,   // write data ready
  input  wire logic [31:0]                wdata,    // write data
  input  wire logic [3:0]                 wstrb,    // write byte strobes
  output logic                            bvalid,   // write response valid
  input  wire logic                       bready,   // write response ready
  output logic [1:0]                      bresp,    // write response
  input  wire logic                       arvalid,  // read address valid
  output logic                            arready,  // read address ready
  input  wire logic [7:0]                 araddr,   // read byte address
  output logic                            rvalid,   // read data valid
  input  wire logic                       rready,   // read data ready
  output logic [31:0]                     rdata,    // read data
  output logic [1:0]                      rresp,    // read response
  output logic                            relay_out // relay coil drive
);
  borl_pkg::borl_state_t st;        // registered state
  borl_pkg::borl_state_t next_st;   // next state
  logic                  req;       // combined pick-up request
  logic                  ack;       // selected acknowledgement
  logic [31:0]           rd_word;   // decoded read value
  logic                  rd_hit;    // read address mapped

  // picks one signal of the list by its selector
  function automatic logic pick(input logic [borl_pkg::SIG_W-1:0] list,
                                input logic [borl_pkg::SEL_W-1:0] sel);
    pick = list[sel];
  endfunction : pick

  // write enable of a register at a given offset
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = (a[7:2] == ofs[7:2]);
  endfunction : wr_hit

  // handshake outputs are combinational from state
  assign awready   = !st.awdone && !st.bvalid;
  assign wready    = !st.wdone && !st.bvalid;
  assign arready   = !st.rvalid;
  assign bvalid    = st.bvalid;
  assign bresp     = st.bresp;
  assign rvalid    = st.rvalid;
  assign rdata     = st.rdata;
  assign rresp     = st.rresp;
  assign relay_out = st.relay;

  // request: or over assigned slots, each after its own inversion
  always_comb begin
    req = 1'b0;
    for (int i = 0; i < borl_pkg::NUM_SLOTS; i++) begin
      if (st.slot_en[i]) begin
        req = req | (pick(sig_list, st.slot_sel[i*borl_pkg::SEL_W +: borl_pkg::SEL_W])
                     ^ st.slot_inv[i]); // [RQ5] [RQ6]
      end
    end
    ack = pick(sig_list, st.ack_sel); // [RQ3]
  end

  // read decode; unmapped reads answer slverr with zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (araddr[7:2] == borl_pkg::OFS_CTRL[7:2]) begin
      rd_word[borl_pkg::BIT_LATCH]  = st.latch_en;
      rd_word[borl_pkg::BIT_RLYINV] = st.rly_inv;
    end else if (araddr[7:2] == borl_pkg::OFS_ACKSEL[7:2]) begin
      rd_word[borl_pkg::SEL_W-1:0] = st.ack_sel;
    end else if (araddr[7:2] == borl_pkg::OFS_SLOTINV[7:2]) begin
      rd_word[borl_pkg::NUM_SLOTS-1:0] = st.slot_inv;
    end else if (araddr[7:2] == borl_pkg::OFS_STATUS[7:2]) begin
      rd_word[borl_pkg::BIT_ST_RLY]  = st.relay;
      rd_word[borl_pkg::BIT_ST_HOLD] = st.hold;
      rd_word[borl_pkg::BIT_ST_REQ]  = req;
    end else begin
      rd_hit = 1'b0;
      for (int i = 0; i < borl_pkg::NUM_SLOTS; i++) begin
        if (araddr[7:2] == 6'(borl_pkg::OFS_SEL0[7:2] + 6'(i))) begin
          rd_hit = 1'b1;
          rd_word[borl_pkg::SEL_W-1:0] = st.slot_sel[i*borl_pkg::SEL_W +: borl_pkg::SEL_W];
          rd_word[borl_pkg::BIT_SLOTEN] = st.slot_en[i];
        end
      end
    end
  end

  // next-state: bus slave, settings, latch and relay drive
  always_comb begin
    logic wr_ok;    // write hit a mapped register
    logic picked;   // state before relay inversion
    next_st = st;
    wr_ok   = 1'b0;
    picked  = 1'b0;
    // capture address and data in either order
    if (awvalid && awready) begin
      next_st.awdone = 1'b1;
      next_st.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.wdone = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    // perform the write once both halves are held
    if (st.awdone && st.wdone) begin
      next_st.awdone = 1'b0;
      next_st.wdone  = 1'b0;
      next_st.bvalid = 1'b1;
      if (st.wstrb[0]) begin
        if (wr_hit(st.awaddr, borl_pkg::OFS_CTRL)) begin
          wr_ok = 1'b1;
          next_st.latch_en = st.wdata[borl_pkg::BIT_LATCH];
          next_st.rly_inv  = st.wdata[borl_pkg::BIT_RLYINV];
        end else if (wr_hit(st.awaddr, borl_pkg::OFS_ACKSEL)) begin
          wr_ok = 1'b1;
          next_st.ack_sel = st.wdata[borl_pkg::SEL_W-1:0]; // [RQ3]
        end else if (wr_hit(st.awaddr, borl_pkg::OFS_SLOTINV)) begin
          wr_ok = 1'b1;
          next_st.slot_inv = st.wdata[borl_pkg::NUM_SLOTS-1:0]; // [RQ5]
        end
      end
      for (int i = 0; i < borl_pkg::NUM_SLOTS; i++) begin
        if (st.awaddr[7:2] == 6'(borl_pkg::OFS_SEL0[7:2] + 6'(i))) begin
          wr_ok = 1'b1;
          if (st.wstrb[0]) begin
            next_st.slot_sel[i*borl_pkg::SEL_W +: borl_pkg::SEL_W] =
              st.wdata[borl_pkg::SEL_W-1:0];
          end
          if (st.wstrb[1]) begin
            next_st.slot_en[i] = st.wdata[borl_pkg::BIT_SLOTEN];
          end
        end
      end
      // status is read only; strobeless writes to mapped words are okay
      if (wr_hit(st.awaddr, borl_pkg::OFS_CTRL) || wr_hit(st.awaddr, borl_pkg::OFS_ACKSEL)
          || wr_hit(st.awaddr, borl_pkg::OFS_SLOTINV)
          || wr_hit(st.awaddr, borl_pkg::OFS_STATUS)) begin
        wr_ok = 1'b1;
      end
      next_st.bresp = wr_ok ? borl_pkg::RESP_OKAY : borl_pkg::RESP_SLVERR;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    // read channel: one read in flight
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_hit ? borl_pkg::RESP_OKAY : borl_pkg::RESP_SLVERR;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    // latch: set by request, cleared by ack only while latching on.
    // request wins over ack, so a standing fault cannot be acked away
    if (!st.latch_en) begin
      next_st.hold = 1'b0;                    // [RQ2]
    end else if (req) begin
      next_st.hold = 1'b1;                    // [RQ1]
    end else if (ack) begin
      next_st.hold = 1'b0;                    // [RQ2]
    end
    picked = req | (st.latch_en & st.hold);   // [RQ1] [RQ6]
    next_st.relay = picked ^ st.rly_inv;      // [RQ4]
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st          <= '0;
      st.latch_en <= borl_pkg::RST_LATCH;
      st.rly_inv  <= borl_pkg::RST_RLYINV;
      st.slot_inv <= borl_pkg::RST_SLOTINV;
      st.slot_en  <= {borl_pkg::NUM_SLOTS{borl_pkg::RST_SLOTEN}};
      st.slot_sel <= {borl_pkg::NUM_SLOTS{borl_pkg::RST_SEL}};
      st.ack_sel  <= borl_pkg::RST_ACKSEL;
    end else begin
      st <= next_st;
    end
  end
endmodule : borl_relay

// *** tb/borl_sva.sv ***
/* borl_sva: bus and relay checks for borl_relay.
   assumes: bound to every borl_relay instance, one aclk domain. */
`timescale 1ns/10ps
module borl_sva (
  input wire logic        aclk,      // clock
  input wire logic        aresetn,   // sync reset, low active
  input wire logic        relay_out, // relay coil drive
  input wire logic        awvalid,   // write address valid
  input wire logic        awready,   // write address ready
  input wire logic [7:0]  awaddr,    // write byte address
  input wire logic        wvalid,    // write data valid
  input wire logic        wready,    // write data ready
  input wire logic        bvalid,    // write response valid
  input wire logic        bready,    // write response ready
  input wire logic [1:0]  bresp,     // write response
  input wire logic        arvalid,   // read address valid
  input wire logic        arready,   // read address ready
  input wire logic [7:0]  araddr,    // read byte address
  input wire logic        rvalid,    // read data valid
  input wire logic        rready,    // read data ready
  input wire logic [1:0]  rresp,     // read response
  input wire logic [31:0] rdata      // read data
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // accesses beyond the last selector hit no register
  sequence wr_hole_s;
    awvalid && awready && wvalid && wready && awaddr > 8'h2b;
  endsequence
  sequence rd_hole_s;
    arvalid && arready && araddr > 8'h2b;
  endsequence
  // second cycle sees the default settings, so both must stay released
  rly_idle_a: assert property ($rose(aresetn) |-> !relay_out ##1 !relay_out)
    else $error("relay driven right after reset");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  resp_once_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  rdata_once_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");
  ar_block_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("accepted read not answered next cycle");
  wr_refuse_a: assert property (wr_hole_s |-> ##[1:4] (bvalid && bresp == 2'h2))
    else $error("unmapped write not refused");
  rd_refuse_a: assert property (rd_hole_s |=> rvalid && rresp == 2'h2 && rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : borl_sva
bind borl_relay borl_sva i_sva (.*);

// *** tb/borl_contact.sv ***
/* borl_contact: relay contact that closes some cycles after the coil.
   assumes: coil is a registered level on aclk. */
`timescale 1ns/10ps
module borl_contact #(parameter int DLY = 3) (
  input  wire logic aclk,   // clock
  input  wire logic coil,   // coil drive
  output logic      closed  // contact state
);
  logic [7:0] sh = 8'h00;   // coil history, slow armature
  always @(posedge aclk) sh <= {sh[6:0], coil};
  assign closed = sh[DLY-1];
endmodule : borl_contact

// *** tb/borl_relay_tb.sv ***
/* borl_relay_tb: random settings and signals against a cycle model.
   assumes: design takes aw and w together when idle. */
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module borl_relay_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, wa;
  logic [31:0] wdata, sig_list, rnd, rd, wd;
  logic [3:0]  wstrb;
  logic [1:0]  r, ctl;                 // last response, model control
  wire logic   awready, wready, bvalid, arready, rvalid, relay_out, fb;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          n_fail, tests_run;
  logic [4:0]  ack;                    // model ack selector
  logic [6:0]  sinv;                   // model slot inversion
  logic [8:0]  sel [7];                // model selectors
  logic        hold, expv, req, pw;
  logic [3:0]  ws;                     // model captured strobes
  borl_relay i_dut (
    .aclk(aclk), .aresetn(aresetn), .sig_list(sig_list),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .relay_out(relay_out));
  // feedback contact joins the signal list as bit 31
  borl_contact #(.DLY(3)) i_ct (.aclk(aclk), .coil(relay_out), .closed(fb));
  initial begin aclk = 0; forever #5 aclk = ~aclk; end
  function logic [31:0] xs();
    rnd ^= rnd << 13; rnd ^= rnd >> 17; rnd ^= rnd << 5;
    return rnd;
  endfunction : xs
  task print_verdict;
    $display("counts run %0d bad %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // one write: aw and w offered together, each dropped at its own ready,
  // bready held up until bvalid; random strobes keep byte 0 enabled
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic a_done, w_done;
    @(posedge aclk);
    awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= d;
    wstrb <= 4'h1 | 4'(xs());
    bready <= 1;
    a_done = 0; w_done = 0;
    while (!(a_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin a_done = 1; awvalid <= 0; end
      if (wvalid && wready) begin w_done = 1; wvalid <= 0; end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp; bready <= 0;
  endtask : wr
  // one read: rready held up with the request, data taken at rvalid
  task rdx(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    arvalid <= 1; araddr <= a; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    rd = rdata; r = rresp; rready <= 0;
    `CHK(rd, e)
  endtask : rdx
  // cycle model: compare, then step the way the relay logic does
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctl = 0; ack = 5'h1f; sinv = 0; hold = 0; expv = 0; pw = 0; ws = 0;
      foreach (sel[i]) sel[i] = 0;
    end else begin
      `CHK(relay_out, expv)
      req = 0;
      foreach (sel[i]) if (sel[i][8]) req |= sig_list[sel[i][4:0]] ^ sinv[i];
      expv = (req | (ctl[0] & hold)) ^ ctl[1];
      hold = ctl[0] & (req | (hold & !sig_list[ack]));
      if (pw && ws[0] && wa == 8'h00) ctl = wd[1:0];
      if (pw && ws[0] && wa == 8'h04) ack = wd[4:0];
      if (pw && ws[0] && wa == 8'h08) sinv = wd[6:0];
      if (pw && wa >= 8'h10 && wa <= 8'h28) begin
        // selector byte and enable bit follow their own strobes
        if (ws[0]) sel[(wa - 8'h10) >> 2][4:0] = wd[4:0];
        if (ws[1]) sel[(wa - 8'h10) >> 2][8] = wd[8];
      end
      pw = awvalid && awready && wvalid && wready; wa = awaddr; wd = wdata;
      ws = wstrb;
    end
  end
  // watchdog, well past the expected few thousand cycles
  initial begin repeat (20000) @(posedge aclk); n_fail++; print_verdict; end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; sig_list = 0;
    rnd = 32'h09c8b910; n_fail = 0; tests_run = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rdx(8'h00, 0); rdx(8'h04, 32'h1f); rdx(8'h08, 0); rdx(8'h10, 0);
    rdx(8'h0c, 0);
    rdx(8'h40, 0); `CHK(r, 2'h2)
    $display("test reset values done");
    for (int k = 0; k < 24; k++) begin
      for (int i = 0; i < 7; i++) wr(8'h10 + 8'(4 * i), xs() & 32'h11f);
      wr(8'h08, xs() & xs() & xs()); wr(8'h04, xs()); wr(8'h00, 32'(k & 3));
      // sparse signals so requests drop and the latch shows
      repeat (40) begin @(posedge aclk); sig_list <= {fb, 31'(xs() & xs() & xs())}; end
      rdx(8'h00, {30'h0, ctl}); rdx(8'h04, {27'h0, ack});
      rdx(8'h08, {25'h0, sinv});
      for (int i = 0; i < 7; i++) rdx(8'h10 + 8'(4 * i), {23'h0, sel[i]});
      $display("test config %0d done", k);
    end
    // mid-run reset: control and slot inversion settings must fall back to their inactive defaults
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdx(8'h00, 0); rdx(8'h08, 0); rdx(8'h0c, 0);
    $display("test mid reset done");
    wr(8'h30, 32'h1); `CHK(r, 2'h2)
    $display("test bad write done");
    print_verdict;
  end
endmodule : borl_relay_tb
